// ==== rtl/rqsb_buf2.sv ====
// two-entry buffer with valid and ready on both sides
// assumes the drain side holds ready for as long as it likes; head word is a flop
`timescale 1ns/1ps
module rqsb_buf2 #(parameter int W = 8)
(
	input wire logic clk, // system clock
	input wire logic rst_b, // synchronous reset, low
	rqsb_word_if.snk in_w, // filling side
	rqsb_word_if.src out_w // draining side
);
	logic [1:0] cnt_reg;
	logic [W-1:0] slot0_reg;
	logic [W-1:0] slot1_reg;
	logic push;
	logic pop;
	assign in_w.ready = (cnt_reg != 2'h2);
	assign out_w.valid = (cnt_reg != 2'h0);
	assign out_w.data = slot0_reg;
	assign push = in_w.valid & in_w.ready;
	assign pop = out_w.valid & out_w.ready;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt_reg <= 2'h0;
		else if (push && !pop)
			cnt_reg <= cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_reg <= cnt_reg - 2'h1;
	end
	// head always sits in slot0 so the output needs no read mux
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			slot0_reg <= '0;
			slot1_reg <= '0;
		end
		else if (pop)
		begin
			if (cnt_reg == 2'h2)
				slot0_reg <= slot1_reg;
			else if (push)
				slot0_reg <= in_w.data;
		end
		else if (push)
		begin
			if (cnt_reg == 2'h0)
				slot0_reg <= in_w.data;
			else
				slot1_reg <= in_w.data;
		end
	end
	a_buf_hold: assert property (@(posedge clk) disable iff (!rst_b)
		out_w.valid && !out_w.ready |=> out_w.valid && $stable(out_w.data)) // RQ15
		else $error("buffer head changed while stalled");
endmodule // rqsb_buf2

// ==== rtl/rqsb_ctrl.sv ====
// request stream controller: AXI4-Lite registers, packet sequencer, output stage
// assumes the device core shares CLK_SYS and samples the sideband on the first beat
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Functional notes
// [RQ1] first dword byte enables go on sideband bits 3:0
// [RQ2] write packets mark valid bytes of first payload dword there
// [RQ3] device samples byte enables and offset on the first accepted beat
// [RQ4] final dword byte enables go on sideband bits 7:4
// [RQ5] one dword or zero length packets drive final byte enables zero
// [RQ6] multi-dword writes mark valid bytes of the final dword
// [RQ7] address-aligned mode puts start lane modulo 4 on bits 10:8
// [RQ8] dword-alignment mode holds the lane offset at zero
// [RQ9] root-port configuration packets are aligned to lane zero
// [RQ10] bit 11 aborts a packet; device nullifies the matching packet
// [RQ11] after abort, end at once or finish; abort stays raised
// [RQ12] abort raised only with ready high, held until ready high
// [RQ13] abort never used on non-posted requests
// [RQ14] abort never on the first beat of a packet
// [RQ15] beat moves on valid and ready; stalled beats hold steady
module rqsb_ctrl #(parameter int DATA_W = 32)
(
	input wire logic CLK_SYS, // system clock
	input wire logic RST_B, // synchronous reset, low
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	output logic [DATA_W-1:0] REQUEST_DATA, // request payload beat
	output logic REQUEST_LAST, // last beat of packet
	output logic [11:0] REQUEST_SIDEBAND_BUS, // sideband fields
	output logic REQUEST_VALID, // beat valid
	input wire logic REQUEST_READY // device accepts beat
);
	localparam int WW = DATA_W + rqsb_pkg::SB_W + 1;
	// ************************************************************
	// register bus slave
	// ************************************************************
	logic aw_have_reg;
	logic [7:0] aw_addr_reg;
	logic w_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] cfg_reg;
	logic [31:0] len_reg;
	logic [31:0] seed_reg;
	logic refused_reg;
	logic [15:0] pkt_count_reg;
	logic do_write;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_len;
	logic wr_seed;
	logic wr_status;
	logic start_req;
	logic refuse_evt;
	logic busy;
	logic [31:0] sts_word;
	logic [31:0] rd_word;
	logic rd_hit;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction
	assign S_AXI_AWREADY = !aw_have_reg;
	assign S_AXI_WREADY = !w_have_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = !rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	// address and data are taken in either order; the write lands once both are held
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_ctrl = do_write && (aw_addr_reg == rqsb_pkg::OFS_CTRL);
	assign wr_cfg = do_write && (aw_addr_reg == rqsb_pkg::OFS_CONFIG);
	assign wr_len = do_write && (aw_addr_reg == rqsb_pkg::OFS_LENGTH);
	assign wr_seed = do_write && (aw_addr_reg == rqsb_pkg::OFS_SEED);
	assign wr_status = do_write && (aw_addr_reg == rqsb_pkg::OFS_STATUS);
	assign start_req = wr_ctrl && w_strb_reg[0] && w_data_reg[rqsb_pkg::CTRL_START];
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			aw_have_reg <= 1'b0;
		else if (S_AXI_AWVALID && !aw_have_reg)
			aw_have_reg <= 1'b1;
		else if (do_write)
			aw_have_reg <= 1'b0;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			aw_addr_reg <= 8'h00;
		else if (S_AXI_AWVALID && !aw_have_reg)
			aw_addr_reg <= S_AXI_AWADDR;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			w_have_reg <= 1'b0;
			w_data_reg <= rqsb_pkg::REG_RESET;
			w_strb_reg <= 4'h0;
		end
		else if (S_AXI_WVALID && !w_have_reg)
		begin
			w_have_reg <= 1'b1;
			w_data_reg <= S_AXI_WDATA;
			w_strb_reg <= S_AXI_WSTRB;
		end
		else if (do_write)
			w_have_reg <= 1'b0;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= rqsb_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_ctrl || wr_cfg || wr_len || wr_seed || wr_status) ? rqsb_pkg::RESP_OKAY
				: rqsb_pkg::RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			bvalid_reg <= 1'b0;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			cfg_reg <= rqsb_pkg::REG_RESET;
			len_reg <= rqsb_pkg::REG_RESET;
			seed_reg <= rqsb_pkg::REG_RESET;
		end
		else
		begin
			if (wr_cfg)
				cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg);
			if (wr_len)
				len_reg <= merge(len_reg, w_data_reg, w_strb_reg);
			if (wr_seed)
				seed_reg <= merge(seed_reg, w_data_reg, w_strb_reg);
		end
	end
	// a new refusal in the clearing cycle keeps the flag set
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			refused_reg <= 1'b0;
		else if (refuse_evt)
			refused_reg <= 1'b1;
		else if (wr_status && w_strb_reg[0] && w_data_reg[rqsb_pkg::STS_REFUSED])
			refused_reg <= 1'b0;
	end
	always_comb
	begin
		sts_word = rqsb_pkg::REG_RESET;
		sts_word[rqsb_pkg::STS_BUSY] = busy;
		sts_word[rqsb_pkg::STS_REFUSED] = refused_reg;
		sts_word[rqsb_pkg::STS_CNT_LSB +: rqsb_pkg::CNT_W] = pkt_count_reg;
	end
	always_comb
	begin
		rd_hit = 1'b1;
		if (S_AXI_ARADDR == rqsb_pkg::OFS_CONFIG)
			rd_word = cfg_reg;
		else if (S_AXI_ARADDR == rqsb_pkg::OFS_LENGTH)
			rd_word = len_reg;
		else if (S_AXI_ARADDR == rqsb_pkg::OFS_SEED)
			rd_word = seed_reg;
		else if (S_AXI_ARADDR == rqsb_pkg::OFS_STATUS)
			rd_word = sts_word;
		else if (S_AXI_ARADDR == rqsb_pkg::OFS_CTRL)
			rd_word = rqsb_pkg::REG_RESET;
		else
		begin
			rd_word = rqsb_pkg::REG_RESET;
			rd_hit = 1'b0;
		end
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= rqsb_pkg::REG_RESET;
			rresp_reg <= rqsb_pkg::RESP_OKAY;
		end
		else if (S_AXI_ARVALID && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_hit ? rqsb_pkg::RESP_OKAY : rqsb_pkg::RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			rvalid_reg <= 1'b0;
	end
	// ************************************************************
	// packet sequencer
	// ************************************************************
	rqsb_pkg::rqsb_state_t state_reg;
	logic [10:0] beat_reg;
	logic [10:0] pkt_last_reg;
	logic [10:0] pkt_at_reg;
	logic [10:0] sb_low;
	logic [10:0] pkt_sb_reg;
	logic [31:0] pkt_seed_reg;
	logic pkt_abort_on_reg;
	logic pkt_abort_end_reg;
	logic abort_active_reg;
	logic abort_req;
	logic abort_bad;
	logic can_start;
	logic beat_abort;
	logic word_last;
	logic push;
	logic [10:0] len_dw;
	logic [10:0] abort_at;
	rqsb_word_if #(.W(WW)) seq_w ();
	rqsb_word_if #(.W(WW)) out_w ();
	assign len_dw = len_reg[rqsb_pkg::LEN_DW_LSB +: rqsb_pkg::LEN_W];
	assign abort_at = len_reg[rqsb_pkg::LEN_AT_LSB +: rqsb_pkg::LEN_W];
	rqsb_sideband u_sideband
	(
		.first_dword_byte_enables(cfg_reg[rqsb_pkg::CFG_FBE_LSB +: rqsb_pkg::BE_W]),
		.final_dword_byte_enables(cfg_reg[rqsb_pkg::CFG_LBE_LSB +: rqsb_pkg::BE_W]),
		.lane_offset(cfg_reg[rqsb_pkg::CFG_OFS_LSB +: rqsb_pkg::OFS_W]),
		.length_dw(len_dw),
		.dword_mode(cfg_reg[rqsb_pkg::CFG_DWMODE]),
		.root_port(cfg_reg[rqsb_pkg::CFG_ROOT]),
		.cfg_request(cfg_reg[rqsb_pkg::CFG_CFGREQ]),
		.sideband(sb_low)
	);
	// a start while the buffer still holds beats is refused, so packet snapshots never mix
	assign busy = (state_reg != rqsb_pkg::ST_IDLE) || out_w.valid;
	assign abort_req = cfg_reg[rqsb_pkg::CFG_ABORT_EN];
	assign abort_bad = abort_req && (!cfg_reg[rqsb_pkg::CFG_POSTED] || (abort_at == rqsb_pkg::LEN_ZERO));
	assign can_start = start_req && !busy;
	assign refuse_evt = start_req && (busy || abort_bad);
	assign beat_abort = abort_active_reg || (pkt_abort_on_reg && (beat_reg == pkt_at_reg)); // RQ10 RQ11
	assign word_last = (beat_reg == pkt_last_reg) || (beat_abort && pkt_abort_end_reg); // RQ11
	assign seq_w.valid = (state_reg == rqsb_pkg::ST_SEND);
	assign seq_w.data = {word_last, beat_abort, pkt_sb_reg, DATA_W'(pkt_seed_reg + 32'(beat_reg))};
	assign push = seq_w.valid && seq_w.ready;
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			state_reg <= rqsb_pkg::ST_IDLE;
		else
			case (state_reg)
				rqsb_pkg::ST_IDLE:
					if (can_start)
						state_reg <= rqsb_pkg::ST_SEND;
				rqsb_pkg::ST_SEND:
					if (push && word_last)
						state_reg <= rqsb_pkg::ST_IDLE;
				default:
					state_reg <= rqsb_pkg::ST_IDLE;
			endcase
	end
	// fields are snapshotted at start and held on every beat, so the first beat carries them
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			pkt_sb_reg <= 11'h000;
			pkt_last_reg <= 11'h000;
			pkt_at_reg <= 11'h000;
			pkt_seed_reg <= rqsb_pkg::REG_RESET;
			pkt_abort_on_reg <= 1'b0;
			pkt_abort_end_reg <= 1'b0;
		end
		else if (can_start)
		begin
			pkt_sb_reg <= sb_low; // RQ3
			pkt_last_reg <= (len_dw == rqsb_pkg::LEN_ZERO) ? rqsb_pkg::LEN_ZERO : len_dw - rqsb_pkg::LEN_ONE;
			pkt_at_reg <= abort_at;
			pkt_seed_reg <= seed_reg;
			pkt_abort_on_reg <= abort_req && !abort_bad; // RQ13 RQ14
			pkt_abort_end_reg <= cfg_reg[rqsb_pkg::CFG_ABORT_END];
		end
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			beat_reg <= 11'h000;
			abort_active_reg <= 1'b0;
		end
		else if (can_start)
		begin
			beat_reg <= 11'h000;
			abort_active_reg <= 1'b0;
		end
		else if (push)
		begin
			beat_reg <= beat_reg + rqsb_pkg::LEN_ONE;
			if (beat_abort)
				abort_active_reg <= 1'b1; // RQ11
		end
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			pkt_count_reg <= 16'h0000;
		else if (push && word_last)
			pkt_count_reg <= pkt_count_reg + 16'h0001;
	end
	// ************************************************************
	// output stage
	// ************************************************************
	rqsb_buf2 #(.W(WW)) u_buf
	(
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.in_w(seq_w),
		.out_w(out_w)
	);
	assign out_w.ready = REQUEST_READY; // RQ15
	assign REQUEST_VALID = out_w.valid;
	assign REQUEST_DATA = out_w.data[DATA_W-1:0];
	assign REQUEST_LAST = out_w.data[WW-1];
	// abort shows only in a taking cycle: never raised into a stall, never left on an idle bus
	assign REQUEST_SIDEBAND_BUS = {out_w.data[DATA_W + rqsb_pkg::SB_ABORT] & REQUEST_READY & out_w.valid,
		out_w.data[DATA_W +: rqsb_pkg::SB_ABORT]}; // RQ12
	// ************************************************************
	// checks
	// ************************************************************
	logic out_first_reg;
	logic out_aborted_reg;
	logic hs;
	assign hs = REQUEST_VALID && REQUEST_READY;
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			out_first_reg <= 1'b1;
			out_aborted_reg <= 1'b0;
		end
		else if (hs)
		begin
			out_first_reg <= REQUEST_LAST;
			out_aborted_reg <= !REQUEST_LAST && (out_aborted_reg || REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT]);
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// abort may rise when ready returns, so only the fields below it must hold
	a_stall_hold: assert property (REQUEST_VALID && !REQUEST_READY |=> REQUEST_VALID
		&& $stable(REQUEST_DATA) && $stable(REQUEST_LAST)
		&& $stable(REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT-1:0])) // RQ15
		else $error("beat changed during stall");
	a_abort_ready: assert property (REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT] |-> REQUEST_READY && REQUEST_VALID) // RQ12
		else $error("abort raised without ready");
	a_abort_first: assert property (REQUEST_VALID && out_first_reg |-> !REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT]) // RQ14
		else $error("abort on first beat");
	a_abort_sticky: assert property (hs && out_aborted_reg |-> REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT]) // RQ11
		else $error("abort dropped before packet end");
	a_abort_posted: assert property (can_start && !cfg_reg[rqsb_pkg::CFG_POSTED] |=> !pkt_abort_on_reg) // RQ13
		else $error("abort armed on a non-posted packet");
	a_final_be_zero: assert property (REQUEST_VALID && pkt_last_reg == rqsb_pkg::LEN_ZERO
		|-> REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_LBE_LSB +: rqsb_pkg::BE_W] == rqsb_pkg::BE_ZERO) // RQ5
		else $error("final byte enables not zero on short packet");
	a_offset_mod4: assert property (REQUEST_VALID |-> !REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_OFS_LSB + 2]) // RQ7
		else $error("lane offset not modulo 4");
	a_dword_offset: assert property (can_start && cfg_reg[rqsb_pkg::CFG_DWMODE]
		|=> pkt_sb_reg[rqsb_pkg::SB_OFS_LSB +: rqsb_pkg::OFS_W] == rqsb_pkg::OFS_ZERO) // RQ8
		else $error("lane offset nonzero in dword mode");
	a_root_cfg: assert property (can_start && cfg_reg[rqsb_pkg::CFG_ROOT] && cfg_reg[rqsb_pkg::CFG_CFGREQ]
		|=> pkt_sb_reg[rqsb_pkg::SB_OFS_LSB +: rqsb_pkg::OFS_W] == rqsb_pkg::OFS_ZERO) // RQ9
		else $error("root configuration packet not lane aligned");
	a_start_send: assert property (can_start |=> state_reg == rqsb_pkg::ST_SEND ##0 seq_w.valid)
		else $error("start did not begin a packet");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	c_stall: cover property (REQUEST_VALID && !REQUEST_READY ##1 hs);
	c_abort_full: cover property (hs && REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT] && !REQUEST_LAST ##[1:20] hs && REQUEST_LAST);
	c_abort_end: cover property (hs && REQUEST_SIDEBAND_BUS[rqsb_pkg::SB_ABORT] && REQUEST_LAST && out_aborted_reg == 1'b0);
	c_refused: cover property (refuse_evt);
endmodule // rqsb_ctrl

// ==== rtl/rqsb_pkg.sv ====
// register map, field layout and state codes of the request stream controller
// assumes a 32-bit AXI4-Lite register bus and a single system clock
package rqsb_pkg;
	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_LENGTH = 8'h08;
	localparam logic [7:0] OFS_SEED = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// register fields
	// ************************************************************
	localparam int CTRL_START = 0;
	localparam int CFG_FBE_LSB = 0;
	localparam int CFG_LBE_LSB = 4;
	localparam int CFG_OFS_LSB = 8;
	localparam int CFG_DWMODE = 12;
	localparam int CFG_ROOT = 13;
	localparam int CFG_CFGREQ = 14;
	localparam int CFG_POSTED = 15;
	localparam int CFG_ABORT_EN = 16;
	localparam int CFG_ABORT_END = 17;
	localparam int LEN_DW_LSB = 0;
	localparam int LEN_AT_LSB = 16;
	localparam int STS_BUSY = 0;
	localparam int STS_REFUSED = 1;
	localparam int STS_CNT_LSB = 16;
	localparam int CNT_W = 16;
	// ************************************************************
	// sideband bus layout
	// ************************************************************
	localparam int SB_W = 12;
	localparam int BE_W = 4;
	localparam int OFS_W = 3;
	localparam int LEN_W = 11;
	localparam int SB_FBE_LSB = 0;
	localparam int SB_LBE_LSB = 4;
	localparam int SB_OFS_LSB = 8;
	localparam int SB_ABORT = 11;
	localparam logic [3:0] BE_ZERO = 4'h0;
	localparam logic [2:0] OFS_ZERO = 3'h0;
	localparam logic [10:0] LEN_ONE = 11'h001;
	localparam logic [10:0] LEN_ZERO = 11'h000;
	typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_SEND = 2'h2} rqsb_state_t;
endpackage

// ==== rtl/rqsb_sideband.sv ====
// packs byte enables and lane offset into the low sideband field
// assumes the caller snapshots the result once per packet
`timescale 1ns/1ps
module rqsb_sideband
(
	input wire logic [3:0] first_dword_byte_enables, // header first byte enables
	input wire logic [3:0] final_dword_byte_enables, // header last byte enables
	input wire logic [2:0] lane_offset, // payload start lane
	input wire logic [10:0] length_dw, // payload length in dwords
	input wire logic dword_mode, // dword-alignment mode
	input wire logic root_port, // root-port operation
	input wire logic cfg_request, // configuration request
	output logic [10:0] sideband // bits 10:0 of the sideband bus
);
	logic [3:0] final_be_eff;
	logic [2:0] ofs_eff;
	// single dword and zero length carry no last byte enables
	assign final_be_eff = (length_dw <= rqsb_pkg::LEN_ONE) ? rqsb_pkg::BE_ZERO
		: final_dword_byte_enables; // RQ4 RQ5 RQ6
	// offset is modulo 4, forced to lane 0 where alignment demands it
	assign ofs_eff = (dword_mode || (root_port && cfg_request)) ? rqsb_pkg::OFS_ZERO
		: {1'b0, lane_offset[1:0]}; // RQ7 RQ8 RQ9
	assign sideband = {ofs_eff, final_be_eff, first_dword_byte_enables}; // RQ1 RQ2
endmodule // rqsb_sideband

// ==== rtl/rqsb_word_if.sv ====
// stream word carrier between the sequencer, the buffer and the output stage
// assumes both ends share one clock
`timescale 1ns/1ps
interface rqsb_word_if #(parameter int W = 1);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== verification/rqsb_dev_model.sv ====
// device side of the request stream: paces ready and records each packet
// assumes the controller shares the clock and changes the stream after edges
`timescale 1ns/1ps
module rqsb_dev_model
(
	input wire logic clk, // system clock
	input wire logic rst_b, // reset, low
	input wire logic slow, // ready every other cycle
	input wire logic [31:0] data, // beat payload
	input wire logic last, // last beat
	input wire logic [11:0] sb, // sideband bus
	input wire logic valid, // beat valid
	output logic ready, // beat accepted
	output logic [10:0] cap_sb, // sideband of first beat
	output logic [31:0] cap_data, // payload of first beat
	output logic [7:0] beats, // beats of last packet
	output logic nullified, // last packet nullified
	output logic [7:0] bad_cnt // stream faults seen
);
	// ************************************************************
	// pacing and capture
	// ************************************************************
	logic first_reg;
	logic tog_reg;
	logic stall_reg;
	logic [43:0] held_reg;
	logic [31:0] prev_reg;
	logic take;
	assign take = valid & ready;
	assign ready = ~slow | tog_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			first_reg <= 1'b1;
			tog_reg <= 1'b0;
			stall_reg <= 1'b0;
			held_reg <= 44'h0;
			prev_reg <= 32'h0;
			beats <= 8'h00;
			nullified <= 1'b0;
			bad_cnt <= 8'h00;
			cap_sb <= 11'h000;
			cap_data <= 32'h0;
		end
		else
		begin
			tog_reg <= ~tog_reg;
			stall_reg <= valid & ~ready;
			held_reg <= {data, last, sb[10:0]};
			// a stalled beat must come back unchanged
			if (stall_reg && (!valid || held_reg != {data, last, sb[10:0]}))
				bad_cnt <= bad_cnt + 8'h01;
			if (sb[11] && (!ready || first_reg))
				bad_cnt <= bad_cnt + 8'h01;
			if (take)
			begin
				first_reg <= last;
				prev_reg <= data;
				// payload counts up by one from the seed on every later beat
				if (!first_reg && data != prev_reg + 32'h1)
					bad_cnt <= bad_cnt + 8'h01;
				if (first_reg)
				begin
					cap_sb <= sb[10:0];
					cap_data <= data;
				end
				beats <= first_reg ? 8'h01 : beats + 8'h01;
				// abort stays in force for the rest of the packet
				nullified <= (nullified & ~first_reg) | sb[11];
			end
		end
	end
endmodule // rqsb_dev_model

// ==== verification/tb_top.sv ====
// bench: register traffic over AXI4-Lite, packets judged at the device model
// assumes one 10 MHz clock for controller and model
`timescale 1ns/1ps
module tb_top;
	// ************************************************************
	// signals and packet table
	// ************************************************************
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, rq_last, rq_valid, rq_ready, nullified;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rdat, rq_data, cap_data;
	logic [11:0] rq_sb;
	logic [10:0] cap_sb;
	logic [7:0] beats, bad_cnt;
	int miscompares = 0;
	int cmp_count = 0;
	int pk = 0;
	logic [31:0] cf[11] = '{32'h8236, 32'h85FF, 32'h85FF, 32'h13A5, 32'h63A5, 32'h23A5,
		32'h18000, 32'h38000, 32'h10000, 32'h18000, 32'h8000};
	logic [31:0] ln[11] = '{32'h3, 32'h1, 32'h0, 32'h2, 32'h1, 32'h2,
		32'h20004, 32'h20004, 32'h10002, 32'h2, 32'h14};
	logic [10:0] sx[11] = '{11'h236, 11'h10F, 11'h10F, 11'h0A5, 11'h005, 11'h3A5,
		11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
	logic [7:0] bx[11] = '{8'h03, 8'h01, 8'h01, 8'h02, 8'h01, 8'h02, 8'h04, 8'h03, 8'h02, 8'h02, 8'h14};
	logic [10:0] nx = 11'h0C0;
	logic [10:0] rx = 11'h700;
	initial
	begin
		forever #50 clk = ~clk;
	end
	rqsb_ctrl i_dut
	(
		.CLK_SYS(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .REQUEST_DATA(rq_data),
		.REQUEST_LAST(rq_last), .REQUEST_SIDEBAND_BUS(rq_sb), .REQUEST_VALID(rq_valid),
		.REQUEST_READY(rq_ready)
	);
	rqsb_dev_model i_dev
	(
		.clk(clk), .rst_b(rst_b), .slow(slow), .data(rq_data), .last(rq_last), .sb(rq_sb),
		.valid(rq_valid), .ready(rq_ready), .cap_sb(cap_sb), .cap_data(cap_data), .beats(beats),
		.nullified(nullified), .bad_cnt(bad_cnt)
	);
	// ************************************************************
	// access and checking tasks
	// ************************************************************
	task automatic test_done();
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// readies and answers are sampled mid-cycle, so they match what the next edge sees
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, dn;
		n = 0;
		dn = 1'b0;
		@(posedge clk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		while (!dn)
		begin
			@(negedge clk);
			ta = wr ? awready : arready;
			tw = wready;
			dn = wr ? bvalid : rvalid;
			rsp = wr ? bresp : rresp;
			rdat = rdata;
			n++;
			@(posedge clk);
			if (ta)
			begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tw)
				wvalid <= 1'b0;
			if (n > 40)
			begin
				miscompares++;
				test_done();
			end
		end
		bready <= 1'b0;
		rready <= 1'b0;
	endtask
	// the second start lands while the first packet still streams
	task automatic run(input logic [31:0] c, input logic [31:0] l, input logic twice);
		int n;
		n = 0;
		bus(1'b1, rqsb_pkg::OFS_CONFIG, c);
		bus(1'b1, rqsb_pkg::OFS_LENGTH, l);
		bus(1'b1, rqsb_pkg::OFS_SEED, 32'hA500_0000 + l);
		bus(1'b1, rqsb_pkg::OFS_CTRL, 32'h1);
		if (twice)
			bus(1'b1, rqsb_pkg::OFS_CTRL, 32'h1);
		pk++;
		rdat = 32'h1;
		while (rdat[0] && n < 80)
		begin
			bus(1'b0, rqsb_pkg::OFS_STATUS, 32'h0);
			n++;
		end
		if (rdat[0])
		begin
			miscompares++;
			test_done();
		end
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, rqsb_pkg::OFS_CONFIG, 32'h0);
		chk(rdat, rqsb_pkg::REG_RESET);
		bus(1'b0, 8'h20, 32'h0);
		chk({rdat[31:2], rsp}, {30'h0, rqsb_pkg::RESP_SLVERR});
		bus(1'b1, 8'h20, 32'h1);
		chk(32'(rsp), 32'(rqsb_pkg::RESP_SLVERR));
		for (int i = 0; i < 11; i++)
		begin
			slow <= i[0];
			run(cf[i], ln[i], i == 10);
			chk(32'(cap_sb), 32'(sx[i]));
			chk(32'(beats), 32'(bx[i]));
			chk(32'(nullified), 32'(nx[i]));
			chk(cap_data, 32'hA500_0000 + ln[i]);
			chk(32'(rdat[1]), 32'(rx[i]));
			bus(1'b1, rqsb_pkg::OFS_STATUS, 32'h2);
		end
		bus(1'b0, rqsb_pkg::OFS_STATUS, 32'h0);
		chk(rdat, {16'(pk), 16'h0});
		chk(32'(bad_cnt), 32'h0);
		test_done();
	end
endmodule // tb_top
